// ---- ssx_cfg.svh ----
`ifndef SSX_CFG_SVH
`define SSX_CFG_SVH
`define SSX_OFS_DATA_LO    10'h2F0
`define SSX_OFS_DATA_HI    10'h2F1
`define SSX_OFS_CTRL       10'h2F2
`define SSX_OFS_FLAG       10'h2F3
`define SSX_OFS_TRIG       10'h2E7
`define SSX_OFS_READY_PORT 10'h2EC
`define SSX_BIT_TRIG       3
`define SSX_BIT_MODE_HI    3
`define SSX_BIT_MODE_LO    2
`define SSX_BIT_EDGE       1
`define SSX_BIT_IRQ_EN     0
`define SSX_BIT_IRQ_FLAG   0
`define SSX_BIT_GPO_ONE    1
`define SSX_RST_MODE       2'h3
`define SSX_RST_EDGE       1'h0
`define SSX_RST_IRQ_EN     1'h0
`define SSX_RST_GPO        1'h0
`define SSX_BITS_PER_XFER  4'h8
`endif

// ---- ssx_pkg.sv ----
package ssx_pkg;
	typedef enum logic [1:0] {
		SSX_MODE_CLK    = 2'h0,
		SSX_MODE_DIV2   = 2'h1,
		SSX_MODE_DIV4   = 2'h2,
		SSX_MODE_SLAVE  = 2'h3
	} ssx_mode_t;
	typedef enum logic [1:0] {
		SSX_ST_IDLE = 2'h0,
		SSX_ST_LOW  = 2'h1,
		SSX_ST_HIGH = 2'h3
	} ssx_state_t;
endpackage

// ---- ssx_shifter.sv ----
// Function
// - Two-bit clock mode picks system clock, half, quarter, or external slave clock.
// - Master drives the serial clock pin; slave takes clock from that pin.
// - After reset the clock mode selects slave.
// - Master stops after eight clocks and holds the clock pin low.
// - Slave ignores extra clock pulses after eight until a new trigger.
// - Shift clocks are counted; eight means the transfer is complete.
// - Software loads both nibbles then triggers; eight bits shift out.
// - Serial output changes only on the rising shift clock edge.
// - Edge select one samples input on rising edge, zero on falling.
// - Each captured bit advances the shift register by one place.
// - Completion sets the flag always; the request only when enabled.
// - Received byte is readable through both data nibble registers.
// - Build option fixes LSB-first or MSB-first bit order.
// - Build option lets general output bit one carry slave ready.
// - Ready idles low, rises on trigger, falls after eight shift clocks.
// - Build option adds a pull-down on the serial input pin.
// - Build option adds a clock pin pull-down only while slave input.
// - Build option inverts clock pin polarity; edges refer to internal clock.
// - Interrupt flag reads one when set and clears right after reading.
`timescale 1ns/1ps
`include "ssx_cfg.svh"
module ssx_shifter #(
	parameter bit P_MSB_FIRST   = 1'b0,
	parameter bit P_READY_ON_GPO = 1'b1,
	parameter bit P_IN_PULLDOWN  = 1'b1,
	parameter bit P_CLK_PULLDOWN = 1'b1,
	parameter bit P_CLK_INVERT   = 1'b0
) (
	input  wire logic       i_clk_sys,          // System clock 125 MHz
	input  wire logic       i_sys_rst,          // Sync reset, active high
	input  wire logic [9:0] i_addr,             // Register address
	input  wire logic [3:0] i_wdata,            // Write data
	input  wire logic       i_wr,               // Write strobe
	input  wire logic       i_rd,               // Read strobe
	output logic      [3:0] o_rdata,            // Read data, cycle after strobe
	output logic            o_irq,              // Interrupt request level
	input  wire logic       i_serial_in_pin,    // Serial data in
	output logic            o_serial_out_pin,   // Serial data out
	input  wire logic       i_sclk_in,          // Clock pin level in
	output logic            o_sclk_out,         // Clock pin level out
	output logic            o_sclk_oe,          // Clock pin drive enable
	output logic            o_sclk_pulldown,    // Clock pin pull-down enable
	output logic            o_sin_pulldown,     // Serial in pull-down enable
	output logic            o_general_output_bit_one // Output bit one or slave ready
);
	ssx_pkg::ssx_mode_t  mode_r;
	ssx_pkg::ssx_state_t st_r;
	logic [7:0] data_r;
	logic [3:0] cnt_r;
	logic       edge_r;
	logic       irq_en_r;
	logic       flag_r;
	logic       busy_r;
	logic       gpo_r;
	logic       sclk_int_r;
	logic       ext_prev_r;
	logic [1:0] div_r;
	logic       tick;
	logic       ext_lvl;
	logic       rise;
	logic       fall;
	logic       done;
	logic       wr_lo;
	logic       wr_hi;
	logic       wr_ctrl;
	logic       trig;
	logic       rd_flag;
	logic       sample;
	logic       in_bit;
	logic       out_bit;
	logic       sclk_nxt;
	logic [7:0] shift_nxt;
	logic       is_master;
	logic       wr_port;

	// Register decode
	assign wr_lo   = i_wr && (i_addr == `SSX_OFS_DATA_LO);
	assign wr_hi   = i_wr && (i_addr == `SSX_OFS_DATA_HI);
	assign wr_ctrl = i_wr && (i_addr == `SSX_OFS_CTRL);
	assign trig    = i_wr && (i_addr == `SSX_OFS_TRIG) && i_wdata[`SSX_BIT_TRIG];
	assign rd_flag = i_rd && (i_addr == `SSX_OFS_FLAG);
	assign in_bit  = i_serial_in_pin;
	assign ext_lvl = i_sclk_in ^ P_CLK_INVERT;
	assign wr_port = i_wr && (i_addr == `SSX_OFS_READY_PORT);
	assign is_master = (mode_r != ssx_pkg::SSX_MODE_SLAVE);

	// Master clock rate enable
	// Slave mode never ticks; its edges come from the pin
	always_comb begin
		unique case (mode_r)
			ssx_pkg::SSX_MODE_CLK:  tick = 1'b1;
			ssx_pkg::SSX_MODE_DIV2: tick = div_r[0];
			ssx_pkg::SSX_MODE_DIV4: tick = (div_r == 2'h3);
			ssx_pkg::SSX_MODE_SLAVE: tick = 1'b0;
		endcase
	end

	// Free-running divider; master rates tap it
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end

	// Internal shift clock edges
	always_comb begin
		rise = 1'b0;
		fall = 1'b0;
		if (busy_r) begin
			if (mode_r == ssx_pkg::SSX_MODE_SLAVE) begin
				rise = ext_lvl && !ext_prev_r;
				fall = !ext_lvl && ext_prev_r;
			end else if (tick) begin
				rise = (st_r == ssx_pkg::SSX_ST_LOW);
				fall = (st_r == ssx_pkg::SSX_ST_HIGH);
			end
		end
	end
	// Capture edge, completion and outgoing bit
	assign sample = edge_r ? rise : fall;
	assign done   = fall && (cnt_r == `SSX_BITS_PER_XFER);
	assign out_bit = P_MSB_FIRST ? data_r[7] : data_r[0];

	// Previous pin level for slave edge detection
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			ext_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= ext_lvl;
		end
	end

	// Master clock generator
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_r <= ssx_pkg::SSX_ST_IDLE;
		end else if (trig) begin
			st_r <= ssx_pkg::SSX_ST_LOW;
		end else begin
			unique case (st_r)
				ssx_pkg::SSX_ST_IDLE: st_r <= ssx_pkg::SSX_ST_IDLE;
				ssx_pkg::SSX_ST_LOW: begin
					if (rise) begin
						st_r <= ssx_pkg::SSX_ST_HIGH;
					end
				end
				ssx_pkg::SSX_ST_HIGH: begin
					if (done) begin
						st_r <= ssx_pkg::SSX_ST_IDLE;
					end else if (fall) begin
						st_r <= ssx_pkg::SSX_ST_LOW;
					end
				end
				default: st_r <= ssx_pkg::SSX_ST_IDLE;
			endcase
		end
	end

	// Next internal clock level; the pin flop uses it so clock and data leave together
	always_comb begin
		sclk_nxt = sclk_int_r;
		if (rise) begin
			sclk_nxt = 1'b1;
		end else if (fall || trig) begin
			sclk_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			sclk_int_r <= 1'b0;
		end else begin
			sclk_int_r <= sclk_nxt;
		end
	end

	// Transfer state and bit counter
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			busy_r <= 1'b0;
			cnt_r  <= 4'h0;
		end else if (trig) begin
			busy_r <= 1'b1;
			cnt_r  <= 4'h0;
		end else begin
			if (rise) begin
				cnt_r <= cnt_r + 4'h1;
			end
			if (done) begin
				busy_r <= 1'b0;
			end
		end
	end

	// Next shift value, one slice per bit
	for (genvar b = 0; b < 8; b++) begin : g_shift
		if (P_MSB_FIRST && b == 0) begin : g_first
			assign shift_nxt[b] = in_bit;
		end else if (P_MSB_FIRST) begin : g_up
			assign shift_nxt[b] = data_r[b-1];
		end else if (b == 7) begin : g_last
			assign shift_nxt[b] = in_bit;
		end else begin : g_down
			assign shift_nxt[b] = data_r[b+1];
		end
	end

	// Shift register
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			data_r <= 8'h00;
		end else if (wr_lo) begin
			data_r[3:0] <= i_wdata;
		end else if (wr_hi) begin
			data_r[7:4] <= i_wdata;
		end else if (sample) begin
			data_r <= shift_nxt;
		end
	end

	// Output pin updates on rising edges only
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_serial_out_pin <= 1'b0;
		end else if (rise) begin
			o_serial_out_pin <= out_bit;
		end
	end

	// Control register
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			mode_r   <= ssx_pkg::ssx_mode_t'(`SSX_RST_MODE);
			edge_r   <= `SSX_RST_EDGE;
			irq_en_r <= `SSX_RST_IRQ_EN;
		end else if (wr_ctrl) begin
			mode_r   <= ssx_pkg::ssx_mode_t'(i_wdata[`SSX_BIT_MODE_HI:`SSX_BIT_MODE_LO]);
			edge_r   <= i_wdata[`SSX_BIT_EDGE];
			irq_en_r <= i_wdata[`SSX_BIT_IRQ_EN];
		end
	end

	// Completion flag; set wins over read-clear
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			flag_r <= 1'b0;
		end else if (done) begin
			flag_r <= 1'b1;
		end else if (rd_flag) begin
			flag_r <= 1'b0;
		end
	end

	// Request follows the flag only while enabled
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= (flag_r || done) && irq_en_r;
		end
	end

	// Plain output latch for bit one when ready is not routed there
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			gpo_r <= `SSX_RST_GPO;
		end else if (wr_port) begin
			gpo_r <= i_wdata[`SSX_BIT_GPO_ONE];
		end
	end

	// Clock pin level, idle level while the pin is an input
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_sclk_out <= P_CLK_INVERT;
		end else if (!is_master) begin
			o_sclk_out <= P_CLK_INVERT;
		end else begin
			o_sclk_out <= sclk_nxt ^ P_CLK_INVERT;
		end
	end

	// Clock pin drive enable
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_sclk_oe <= 1'b0;
		end else begin
			o_sclk_oe <= is_master;
		end
	end

	// Clock pin pull-down only while the pin is an input
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_sclk_pulldown <= P_CLK_PULLDOWN;
		end else begin
			o_sclk_pulldown <= P_CLK_PULLDOWN && !is_master;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_sin_pulldown <= P_IN_PULLDOWN;
		end else begin
			o_sin_pulldown <= P_IN_PULLDOWN;
		end
	end

	// Ready tracks the transfer and drops on the completing edge
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_general_output_bit_one <= 1'b0;
		end else if (P_READY_ON_GPO) begin
			o_general_output_bit_one <= (busy_r || trig) && !done;
		end else begin
			o_general_output_bit_one <= gpo_r;
		end
	end

	// Register read port
	// Unmapped reads and idle cycles return zero
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_rdata <= 4'h0;
		end else if (i_rd) begin
			unique case (i_addr)
				`SSX_OFS_DATA_LO: o_rdata <= data_r[3:0];
				`SSX_OFS_DATA_HI: o_rdata <= data_r[7:4];
				`SSX_OFS_CTRL:    o_rdata <= {mode_r, edge_r, irq_en_r};
				`SSX_OFS_FLAG:    o_rdata <= {3'h0, flag_r};
				default:          o_rdata <= 4'h0;
			endcase
		end else begin
			o_rdata <= 4'h0;
		end
	end
endmodule

// ---- ssx_shifter_checker.sv ----
`timescale 1ns/1ps
module ssx_shifter_checker (
	input wire logic       i_clk_sys,
	input wire logic       i_sys_rst,
	input wire logic [9:0] i_addr,
	input wire logic [3:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [3:0] o_rdata,
	input wire logic       o_serial_out_pin,
	input wire logic       o_sclk_out,
	input wire logic       o_sclk_oe,
	input wire logic       o_sclk_pulldown,
	input wire logic       o_sin_pulldown,
	input wire logic       o_general_output_bit_one
);
	logic [3:0] cnt_r;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	sequence trig_s;
		i_wr && i_addr == 10'h2E7 && i_wdata[3];
	endsequence
	sequence flag_rd_s;
		i_rd && i_addr == 10'h2F3 && !o_general_output_bit_one;
	endsequence
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || (i_wr && i_addr == 10'h2E7 && i_wdata[3])) begin
			cnt_r <= 4'h0;
		end else if (o_sclk_oe && $rose(o_sclk_out)) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	AST_RST: assert property ($fell(i_sys_rst) |-> o_sclk_pulldown && !o_sclk_oe)
		else $error("clock pin not in slave state after reset");
	AST_PD: assert property (o_sclk_pulldown |-> !o_sclk_oe && !o_sclk_out)
		else $error("clock pin driven while pulled down");
	AST_SIN: assert property (o_sin_pulldown)
		else $error("serial input pull-down off");
	AST_TRIG: assert property (trig_s |-> ##[1:2] o_general_output_bit_one)
		else $error("ready not raised by trigger");
	AST_SERIAL_OUT_PIN: assert property ($changed(o_serial_out_pin) && o_sclk_oe && $past(o_sclk_oe)
		|-> o_sclk_out || $past(o_sclk_out))
		else $error("serial out moved away from rising edge");
	AST_STOP: assert property ($fell(o_general_output_bit_one) && o_sclk_oe |-> (!o_sclk_out) [*4])
		else $error("clock pin not held low after transfer");
	AST_CNT: assert property ($fell(o_general_output_bit_one) && o_sclk_oe |-> cnt_r == 4'h8)
		else $error("transfer did not take eight clocks");
	AST_FLAG: assert property (flag_rd_s ##2 flag_rd_s |=> o_rdata == 4'h0)
		else $error("flag not cleared by read");
endmodule
bind ssx_shifter ssx_shifter_checker i_ssx_shifter_checker (.*);

// ---- ssx_partner.sv ----
`timescale 1ns/1ps
module ssx_partner (
	input  wire logic       i_clk,   // Clock
	input  wire logic       i_go,    // Restart
	input  wire logic       i_gen,   // Start clocking
	input  wire logic       i_se,    // Capture on rising
	input  wire logic       i_pin,   // Clock pin
	input  wire logic       i_serial_out_pin,  // Block serial out
	input  wire logic [3:0] i_half,  // Half period
	input  wire logic [3:0] i_extra, // Surplus pulses
	input  wire logic [7:0] i_tx,    // Byte to send
	output logic            o_drv,   // Clock level
	output logic            o_drv_en, // Clock drive
	output logic            o_sin,   // Serial data
	output logic [7:0]      o_rx     // Byte received
);
	logic pin_r;
	int   wi, ri, ph, n, idx;
	assign o_drv_en = n != 0;
	// Counted edges, including one seen at this edge; capture on rise gets its first bit before the first rise
	assign idx = wi + int'(i_pin != pin_r && i_pin == !i_se) - int'(!i_se);
	assign o_sin = i_tx[idx[2:0]] ^ (idx > 7);
	always_ff @(posedge i_clk) begin
		pin_r <= i_pin;
		if (i_go) begin
			{wi, ri, ph, n} <= '0;
			o_drv <= 1'b0;
		end else begin
			// Data moves on the edge the block does not capture on
			if (i_pin != pin_r && i_pin == !i_se) wi <= wi + 1;
			if (!i_pin && pin_r && ri < 8) begin
				o_rx[ri[2:0]] <= i_serial_out_pin;
				ri <= ri + 1;
			end
			if (i_gen) n <= 2 * (8 + int'(i_extra));
			else if (n != 0 && ph + 1 == int'(i_half)) begin
				ph <= 0;
				o_drv <= !o_drv;
				n <= n - 1;
			end else if (n != 0) ph <= ph + 1;
		end
	end
endmodule

// ---- ssx_shifter_test.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch at %0t: %h vs %h", $time, g, e); end end
module ssx_shifter_test;
	logic       clk, rst, wr, rd, go, gen, se, serial_in_pin, serial_out_pin, sclk, oe, drv, den, gpo, irq;
	logic [9:0] addr;
	logic [3:0] wd, rdat, half, extra;
	logic [7:0] tx, prx;
	int         fail_count, cmp_count, seed;
	wire        pin = oe ? sclk : (den ? drv : 1'b0);
	ssx_shifter i_ssx_shifter (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdat), .o_irq(irq), .i_serial_in_pin(serial_in_pin), .o_serial_out_pin(serial_out_pin),
		.i_sclk_in(pin), .o_sclk_out(sclk), .o_sclk_oe(oe), .o_sclk_pulldown(), .o_sin_pulldown(),
		.o_general_output_bit_one(gpo));
	ssx_partner i_ssx_partner (.i_clk(clk), .i_go(go), .i_gen(gen), .i_se(se), .i_pin(pin), .i_serial_out_pin(serial_out_pin),
		.i_half(half), .i_extra(extra), .i_tx(tx), .o_drv(drv), .o_drv_en(den), .o_sin(serial_in_pin), .o_rx(prx));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic wr_reg(input logic [9:0] a, input logic [3:0] d);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [3:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdat, e)
		@(posedge clk);
	endtask
	task automatic xfer(input logic [1:0] m, input logic s, e, input logic [3:0] x);
		logic [7:0] d;
		int         k;
		d = 8'($random(seed));
		k = 0;
		tx <= 8'($random(seed));
		se <= s;
		extra <= x;
		go <= 1'b1;
		wr_reg(10'h2F0, d[3:0]);
		go <= 1'b0;
		wr_reg(10'h2F1, d[7:4]);
		wr_reg(10'h2F2, {m, s, e});
		wr_reg(10'h2E7, 4'h8);
		if (m == 2'h3) begin
			`CHK(gpo, 1'b1)
			gen <= 1'b1;
			@(posedge clk);
			gen <= 1'b0;
		end
		while ((gpo || den) && k < 900) begin
			@(posedge clk);
			k++;
		end
		if (m != 2'h3) `CHK(k > (16 << m) - 5 && k < (16 << m) + 4, 1'b1)
		`CHK(oe, m != 2'h3)
		`CHK(irq, e)
		rd_chk(10'h2F3, 4'h1);
		rd_chk(10'h2F3, 4'h0);
		rd_chk(10'h2F0, tx[3:0]);
		rd_chk(10'h2F1, tx[7:4]);
		`CHK(prx, d)
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		seed = 32'h19279A26;
		{rst, go, wr, rd, gen, se} = 6'h30;
		{addr, wd, half, extra, tx} = '0;
		fail_count = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		half <= 4'h4;
		@(posedge clk);
		rd_chk(10'h2F2, 4'hC);
		rd_chk(10'h000, 4'h0);
		for (int m = 0; m < 3; m++) xfer(2'(m), 1'b0, 1'(m), 4'h0);
		xfer(2'h3, 1'b0, 1'b1, 4'h3);
		xfer(2'h3, 1'b1, 1'b0, 4'h0);
		conclude();
	end
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule
